//--- hdl/fault_zone_pkg.sv
package fault_zone_pkg;

  // ==========================================================
  // Channel and zone layout
  localparam int NUM_CHANNELS = 8;
  localparam int CH_PER_ZONE = 4;
  localparam int NUM_FAULT_PINS = 4;

  // ==========================================================
  // Command codes (values are arbitrary)
  localparam logic [7:0] CMD_CONFIG_ALL = 8'hd1;
  localparam logic [7:0] CMD_PROPAGATE_A = 8'hd2;
  localparam logic [7:0] CMD_PROPAGATE_B = 8'hd3;
  localparam logic [7:0] CMD_PWRGD_EN = 8'hd4;
  localparam logic [7:0] CMD_RESPONSE_Z0A = 8'hd5;
  localparam logic [7:0] CMD_RESPONSE_Z0B = 8'hd6;
  localparam logic [7:0] CMD_RESPONSE_Z1A = 8'hd7;
  localparam logic [7:0] CMD_RESPONSE_Z1B = 8'hd8;
  localparam logic [7:0] CMD_PIN_STATUS = 8'hd9;

  // ==========================================================
  // Global configuration fields
  localparam int CFG_PEC_BIT = 2;
  localparam int CFG_LONG_TIMEOUT_BIT = 1;
  localparam int CFG_WPU_DIS_BIT = 0;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h1cff;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ==========================================================
  // Power-good enable fields
  localparam int PG_WDOG_BIT = 8;
  localparam logic [15:0] PG_WRITE_MASK = 16'h01ff;
  localparam logic [15:0] PG_RESET = 16'h0000;

  // ==========================================================
  // Other reset values and long-timeout factor
  localparam logic [7:0] PROP_RESET = 8'h00;
  localparam logic [3:0] RESP_RESET = 4'h0;
  localparam int LONG_TIMEOUT_FACTOR = 8;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int FAULT_FILTER_NS = 10000;
  localparam int FAULT_FILTER_CYCLES =
    (FAULT_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILTER_W = 11;
  localparam logic [FILTER_W-1:0] FILTER_LIMIT = FILTER_W'(FAULT_FILTER_CYCLES);

endpackage

//--- hdl/fault_zone_powergood.sv
// How it works
// - Packet-error-check bit low: check byte optional; high: check byte required.
// - Long-timeout bit multiplies the bus inactivity timeout by eight.
// - Pull-up-disable low: weak pull-up on input enable unless fault forced off.
// - Pull-up-disable high: input enable driver released unless fault forced off.
// - Channels 0-3 reach only zone 0 pins, channels 4-7 only zone 1 pins.
// - First propagate bit set: faulted-off channel pulls its zone's first pin low.
// - Second propagate bit set: faulted-off channel pulls its zone's second pin low.
// - A low fault pin never affects a channel whose response bit is zero.
// - Propagate bits 15 to 1 ignore writes and read as zero.
// - Power-good pin high only when every enabled channel not left out reports good.
// - A channel with its enable bit clear does not touch power good.
// - Watchdog enable set: watchdog not-expired joins the power-good AND.
// - Watchdog enable clear: watchdog expiry does not alter power good.
// - Odd channels in high-resolution mode are left out of power good.
// - Power-good enable bits 15 to 9 are read-only zero.
// - Responding channel shuts down after pin low 10 us; restarts on release.
// - Fault-pin shutdown pulls alert low and sets the channel's status bit.
`timescale 1ns/1ps
`default_nettype none

module fault_zone_powergood #(
  parameter int BASE_TIMEOUT_CYCLES = 3125000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command port from the bus transaction layer
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [2:0] cmd_page,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_rdata,
  // Bus protocol control
  input wire logic bus_busy,
  input wire logic bus_activity,
  output logic pec_required,
  output logic bus_timeout,
  // Input enable pin
  input wire logic vin_en_forced_off,
  output logic vin_en_pullup_on,
  output logic vin_en_out,
  output logic vin_en_oe_n,
  // Channel status
  input wire logic [7:0] ch_faulted_off,
  input wire logic [7:0] ch_power_good,
  input wire logic [7:0] ch_high_res,
  input wire logic wdog_not_expired,
  output logic [7:0] ch_fault_pin_shutdown,
  output logic power_good,
  // Zone fault pins, open drain
  input wire logic zone0_fault_pin_a_in,
  output logic zone0_fault_pin_a_out,
  output logic zone0_fault_pin_a_oe_n,
  input wire logic zone0_fault_pin_b_in,
  output logic zone0_fault_pin_b_out,
  output logic zone0_fault_pin_b_oe_n,
  input wire logic zone1_fault_pin_a_in,
  output logic zone1_fault_pin_a_out,
  output logic zone1_fault_pin_a_oe_n,
  input wire logic zone1_fault_pin_b_in,
  output logic zone1_fault_pin_b_out,
  output logic zone1_fault_pin_b_oe_n,
  // Alert pin, open drain
  output logic alert_output_out,
  output logic alert_output_oe_n
);

  // ==========================================================
  // State
  logic [15:0] config_reg, config_next;
  logic [7:0] prop_a_reg, prop_a_next;
  logic [7:0] prop_b_reg, prop_b_next;
  logic [15:0] pg_en_reg, pg_en_next;
  logic [3:0] resp_reg [4];
  logic [3:0] resp_next [4];
  logic [7:0] status_reg, status_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic rsp_error_reg, rsp_error_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [31:0] tmo_cnt_reg, tmo_cnt_next;
  logic tmo_reg, tmo_next;
  logic [fault_zone_pkg::FILTER_W-1:0] filt_reg [4];
  logic [fault_zone_pkg::FILTER_W-1:0] filt_next [4];
  logic [7:0] shut_reg, shut_next;
  logic [3:0] pin_oe_n_reg, pin_oe_n_next;
  logic pg_reg, pg_next;
  logic pullup_reg, pullup_next;
  logic vin_oe_n_reg, vin_oe_n_next;

  logic [3:0] pin_level;
  logic [3:0] pin_qualified;
  logic [31:0] tmo_limit;
  logic [7:0] pg_excluded;

  // Pin index: 0 zone0 a, 1 zone0 b, 2 zone1 a, 3 zone1 b
  function automatic logic [1:0] pin_index(input logic zone, input logic second);
    pin_index = {zone, second};
  endfunction

  function automatic logic zone_of(input int ch);
    zone_of = (ch >= fault_zone_pkg::CH_PER_ZONE);
  endfunction

  // ==========================================================
  // Pin sensing
  // Sense the wire, not our own drive, so other managers are seen too
  // wired-AND sensing
  assign pin_level = {zone1_fault_pin_b_in, zone1_fault_pin_a_in,
                      zone0_fault_pin_b_in, zone0_fault_pin_a_in};

  always_comb begin
    for (int p = 0; p < fault_zone_pkg::NUM_FAULT_PINS; p++) begin
      pin_qualified[p] = (filt_reg[p] >= fault_zone_pkg::FILTER_LIMIT);
    end
  end

  assign tmo_limit = config_reg[fault_zone_pkg::CFG_LONG_TIMEOUT_BIT] ?
                     32'(BASE_TIMEOUT_CYCLES * fault_zone_pkg::LONG_TIMEOUT_FACTOR) :
                     32'(BASE_TIMEOUT_CYCLES);

  always_comb begin
    for (int c = 0; c < fault_zone_pkg::NUM_CHANNELS; c++) begin
      pg_excluded[c] = (c % 2 == 1) && ch_high_res[c];
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [7:0] shut_rise;
    logic [15:0] rd;
    logic hit;
    shut_rise = 8'h00;
    rd = 16'h0000;
    hit = 1'b1;
    config_next = config_reg;
    prop_a_next = prop_a_reg;
    prop_b_next = prop_b_reg;
    pg_en_next = pg_en_reg;
    for (int p = 0; p < 4; p++) begin
      resp_next[p] = resp_reg[p];
    end
    status_next = status_reg;

    // Command decode; propagate bits are held per page
    unique case (cmd_code)
      fault_zone_pkg::CMD_CONFIG_ALL: rd = config_reg;
      fault_zone_pkg::CMD_PROPAGATE_A: rd = {15'h0000, prop_a_reg[cmd_page]};
      fault_zone_pkg::CMD_PROPAGATE_B: rd = {15'h0000, prop_b_reg[cmd_page]};
      fault_zone_pkg::CMD_PWRGD_EN: rd = pg_en_reg & fault_zone_pkg::PG_WRITE_MASK;
      fault_zone_pkg::CMD_RESPONSE_Z0A: rd = {12'h000, resp_reg[0]};
      fault_zone_pkg::CMD_RESPONSE_Z0B: rd = {12'h000, resp_reg[1]};
      fault_zone_pkg::CMD_RESPONSE_Z1A: rd = {12'h000, resp_reg[2]};
      fault_zone_pkg::CMD_RESPONSE_Z1B: rd = {12'h000, resp_reg[3]};
      fault_zone_pkg::CMD_PIN_STATUS: rd = {8'h00, status_reg};
      default: hit = 1'b0;
    endcase

    if (cmd_valid && cmd_write && hit) begin
      unique case (cmd_code)
        fault_zone_pkg::CMD_CONFIG_ALL:
          config_next = cmd_wdata & fault_zone_pkg::CFG_WRITE_MASK;
        fault_zone_pkg::CMD_PROPAGATE_A: prop_a_next[cmd_page] = cmd_wdata[0];
        fault_zone_pkg::CMD_PROPAGATE_B: prop_b_next[cmd_page] = cmd_wdata[0];
        fault_zone_pkg::CMD_PWRGD_EN:
          pg_en_next = cmd_wdata & fault_zone_pkg::PG_WRITE_MASK;
        fault_zone_pkg::CMD_RESPONSE_Z0A: resp_next[0] = cmd_wdata[3:0];
        fault_zone_pkg::CMD_RESPONSE_Z0B: resp_next[1] = cmd_wdata[3:0];
        fault_zone_pkg::CMD_RESPONSE_Z1A: resp_next[2] = cmd_wdata[3:0];
        fault_zone_pkg::CMD_RESPONSE_Z1B: resp_next[3] = cmd_wdata[3:0];
        // Write one to clear
        fault_zone_pkg::CMD_PIN_STATUS: status_next = status_reg & ~cmd_wdata[7:0];
        default: status_next = status_reg;
      endcase
    end

    rsp_valid_next = cmd_valid;
    rsp_error_next = cmd_valid && !hit;
    rdata_next = (cmd_valid && !cmd_write && hit) ? rd : 16'h0000;

    // Bus inactivity timer; holds at the limit so the pulse fires once
    tmo_cnt_next = tmo_cnt_reg;
    tmo_next = 1'b0;
    if (!bus_busy || bus_activity) begin
      tmo_cnt_next = 32'h0000_0000;
    end else if (tmo_cnt_reg < tmo_limit) begin
      tmo_cnt_next = tmo_cnt_reg + 32'h0000_0001;
      tmo_next = (tmo_cnt_reg + 32'h0000_0001 == tmo_limit);
    end

    for (int p = 0; p < 4; p++) begin
      if (pin_level[p]) begin
        filt_next[p] = '0;
      end else if (!pin_qualified[p]) begin
        filt_next[p] = filt_reg[p] + fault_zone_pkg::FILTER_W'(1);
      end else begin
        filt_next[p] = filt_reg[p];
      end
    end

    // Shutdown ends as soon as the pin releases; restart timing is downstream
    for (int c = 0; c < fault_zone_pkg::NUM_CHANNELS; c++) begin
      shut_next[c] =
        (pin_qualified[pin_index(zone_of(c), 1'b0)] && resp_reg[pin_index(zone_of(c), 1'b0)][c % 4]) ||
        (pin_qualified[pin_index(zone_of(c), 1'b1)] && resp_reg[pin_index(zone_of(c), 1'b1)][c % 4]);
    end
    shut_rise = shut_next & ~shut_reg;
    status_next = status_next | shut_rise;

    pin_oe_n_next = 4'hf;
    for (int c = 0; c < fault_zone_pkg::NUM_CHANNELS; c++) begin
      if (ch_faulted_off[c] && prop_a_reg[c]) begin
        pin_oe_n_next[pin_index(zone_of(c), 1'b0)] = 1'b0;
      end
      if (ch_faulted_off[c] && prop_b_reg[c]) begin
        pin_oe_n_next[pin_index(zone_of(c), 1'b1)] = 1'b0;
      end
    end

    pg_next = 1'b1;
    for (int c = 0; c < fault_zone_pkg::NUM_CHANNELS; c++) begin
      if (pg_en_reg[c] && !pg_excluded[c] && !ch_power_good[c]) begin
        pg_next = 1'b0;
      end
    end
    if (pg_en_reg[fault_zone_pkg::PG_WDOG_BIT] && !wdog_not_expired) begin
      pg_next = 1'b0;
    end

    pullup_next = !vin_en_forced_off && !config_reg[fault_zone_pkg::CFG_WPU_DIS_BIT];
    vin_oe_n_next = !vin_en_forced_off;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      config_reg <= fault_zone_pkg::CFG_RESET;
      prop_a_reg <= fault_zone_pkg::PROP_RESET;
      prop_b_reg <= fault_zone_pkg::PROP_RESET;
      pg_en_reg <= fault_zone_pkg::PG_RESET;
      for (int p = 0; p < 4; p++) begin
        resp_reg[p] <= fault_zone_pkg::RESP_RESET;
        filt_reg[p] <= '0;
      end
      status_reg <= 8'h00;
      rsp_valid_reg <= 1'b0;
      rsp_error_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      tmo_cnt_reg <= 32'h0000_0000;
      tmo_reg <= 1'b0;
      shut_reg <= 8'h00;
      pin_oe_n_reg <= 4'hf;
      pg_reg <= 1'b0;
      pullup_reg <= 1'b0;
      vin_oe_n_reg <= 1'b1;
    end else begin
      config_reg <= config_next;
      prop_a_reg <= prop_a_next;
      prop_b_reg <= prop_b_next;
      pg_en_reg <= pg_en_next;
      for (int p = 0; p < 4; p++) begin
        resp_reg[p] <= resp_next[p];
        filt_reg[p] <= filt_next[p];
      end
      status_reg <= status_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_error_reg <= rsp_error_next;
      rdata_reg <= rdata_next;
      tmo_cnt_reg <= tmo_cnt_next;
      tmo_reg <= tmo_next;
      shut_reg <= shut_next;
      pin_oe_n_reg <= pin_oe_n_next;
      pg_reg <= pg_next;
      pullup_reg <= pullup_next;
      vin_oe_n_reg <= vin_oe_n_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rsp_valid = rsp_valid_reg;
  assign rsp_error = rsp_error_reg;
  assign rsp_rdata = rdata_reg;
  assign pec_required = config_reg[fault_zone_pkg::CFG_PEC_BIT];
  assign bus_timeout = tmo_reg;
  assign vin_en_pullup_on = pullup_reg;
  assign vin_en_out = 1'b0;
  assign vin_en_oe_n = vin_oe_n_reg;
  assign ch_fault_pin_shutdown = shut_reg;
  assign power_good = pg_reg;
  assign zone0_fault_pin_a_out = 1'b0;
  assign zone0_fault_pin_b_out = 1'b0;
  assign zone1_fault_pin_a_out = 1'b0;
  assign zone1_fault_pin_b_out = 1'b0;
  assign zone0_fault_pin_a_oe_n = pin_oe_n_reg[0];
  assign zone0_fault_pin_b_oe_n = pin_oe_n_reg[1];
  assign zone1_fault_pin_a_oe_n = pin_oe_n_reg[2];
  assign zone1_fault_pin_b_oe_n = pin_oe_n_reg[3];
  // alert held low while status set
  assign alert_output_out = 1'b0;
  assign alert_output_oe_n = ~|status_reg;

endmodule // fault_zone_powergood

`default_nettype wire

//--- sim/fault_zone_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Other manager on the shared fault pins
module fault_zone_peer (
  // Clock
  input wire logic ref_clk,
  // Pull requests from the bench, bit i for pin i
  input wire logic [3:0] hold_low,
  // Open-drain drive, low while pulling
  output logic [3:0] pull_oe_n
);
  initial pull_oe_n = 4'hf;
  // pull low only
  // Released pins are left to the pull-up, never driven high
  always @(posedge ref_clk) begin
    pull_oe_n <= ~hold_low;
  end
endmodule // fault_zone_peer
`default_nettype wire

//--- sim/fault_zone_powergood_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fault_zone_powergood_sva #(
  parameter int BASE_TIMEOUT_CYCLES = 3125000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  // Bus timer
  input wire logic bus_busy,
  input wire logic bus_activity,
  input wire logic bus_timeout,
  // Input enable
  input wire logic vin_en_forced_off,
  input wire logic vin_en_pullup_on,
  input wire logic vin_en_oe_n,
  // Channels
  input wire logic [7:0] ch_faulted_off,
  input wire logic [7:0] ch_power_good,
  input wire logic [7:0] ch_high_res,
  input wire logic wdog_not_expired,
  input wire logic [7:0] ch_fault_pin_shutdown,
  input wire logic power_good,
  // Fault and alert pins
  input wire logic zone0_fault_pin_a_in,
  input wire logic zone0_fault_pin_b_in,
  input wire logic zone0_fault_pin_a_oe_n,
  input wire logic zone0_fault_pin_b_oe_n,
  input wire logic zone1_fault_pin_a_oe_n,
  input wire logic zone1_fault_pin_b_oe_n,
  input wire logic alert_output_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  localparam int LONG_T = BASE_TIMEOUT_CYCLES * fault_zone_pkg::LONG_TIMEOUT_FACTOR;
  // ==========================================================
  // Low-time and idle-time counters
  logic [10:0] low_a_reg, low_a_next, low_b_reg, low_b_next;
  logic [31:0] idle_reg, idle_next;
  always_comb begin
    low_a_next = zone0_fault_pin_a_in ? 11'h0 : low_a_reg + 11'(low_a_reg != 11'h7ff);
    low_b_next = zone0_fault_pin_b_in ? 11'h0 : low_b_reg + 11'(low_b_reg != 11'h7ff);
    idle_next = (bus_busy && !bus_activity) ? idle_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_a_reg <= 11'h0;
      low_b_reg <= 11'h0;
      idle_reg <= 32'h0;
    end else begin
      low_a_reg <= low_a_next;
      low_b_reg <= low_b_next;
      idle_reg <= idle_next;
    end
  end
  // ==========================================================
  // Properties
  property p_answer; rsp_valid == $past(cmd_valid); endproperty
  a_answer: assert property (p_answer) else $error("answer count wrong");
  property p_prop_rsvd; cmd_valid && !cmd_write && (cmd_code == fault_zone_pkg::CMD_PROPAGATE_A
    || cmd_code == fault_zone_pkg::CMD_PROPAGATE_B) |=> rsp_rdata[15:1] == 15'h0; endproperty
  a_prop_rsvd: assert property (p_prop_rsvd) else $error("propagate high bits set");
  property p_pg_rsvd; cmd_valid && !cmd_write && cmd_code == fault_zone_pkg::CMD_PWRGD_EN
    |=> rsp_rdata[15:9] == 7'h0; endproperty
  a_pg_rsvd: assert property (p_pg_rsvd) else $error("enable high bits set");
  property p_forced; vin_en_forced_off |=> !vin_en_pullup_on && !vin_en_oe_n; endproperty
  a_forced: assert property (p_forced) else $error("forced off not driven");
  property p_released; !vin_en_forced_off |=> vin_en_oe_n; endproperty
  a_released: assert property (p_released) else $error("input enable driven");
  property p_zone; (zone0_fault_pin_a_oe_n && zone0_fault_pin_b_oe_n || $past(|ch_faulted_off[3:0]))
    && (zone1_fault_pin_a_oe_n && zone1_fault_pin_b_oe_n || $past(|ch_faulted_off[7:4])); endproperty
  a_zone: assert property (p_zone) else $error("pin pulled without zone fault");
  property p_filter; $rose(|ch_fault_pin_shutdown[3:0]) |->
    low_a_reg >= fault_zone_pkg::FILTER_LIMIT || low_b_reg >= fault_zone_pkg::FILTER_LIMIT; endproperty
  a_filter: assert property (p_filter) else $error("shutdown before filter");
  property p_restart; zone0_fault_pin_a_in && zone0_fault_pin_b_in
    |-> ##3 ch_fault_pin_shutdown[3:0] == 4'h0; endproperty
  a_restart: assert property (p_restart) else $error("shutdown held after release");
  property p_alert; (ch_fault_pin_shutdown & ~$past(ch_fault_pin_shutdown)) != 8'h0
    |-> !alert_output_oe_n; endproperty
  a_alert: assert property (p_alert) else $error("alert not pulled");
  property p_pg; !$past(rst) && $past((ch_power_good | (ch_high_res & 8'haa)) == 8'hff
    && wdog_not_expired) |-> power_good; endproperty
  a_pg: assert property (p_pg) else $error("power good missing");
  property p_timeout; bus_timeout |-> $past(bus_busy) && (idle_reg + 3 >= BASE_TIMEOUT_CYCLES
    && idle_reg <= BASE_TIMEOUT_CYCLES + 2 || idle_reg + 3 >= LONG_T && idle_reg <= LONG_T + 2);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout at wrong time");
endmodule // fault_zone_powergood_sva
bind fault_zone_powergood fault_zone_powergood_sva #(
  .BASE_TIMEOUT_CYCLES(BASE_TIMEOUT_CYCLES)) sva_u (.*);
`default_nettype wire

//--- sim/fault_zone_powergood_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_zone_powergood_tb;
  localparam int BASE = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [2:0] cmd_page = 3'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic bus_busy = 1'b0;
  logic bus_activity = 1'b0;
  logic vin_en_forced_off = 1'b0;
  logic [7:0] ch_faulted_off = 8'h00;
  logic [7:0] ch_power_good = 8'h00;
  logic [7:0] ch_high_res = 8'h00;
  logic wdog_not_expired = 1'b1;
  logic [3:0] hold_low = 4'h0;
  logic rsp_valid, rsp_error, pec_required, bus_timeout, vin_en_pullup_on, vin_en_oe_n;
  logic power_good, alert_output_oe_n, er;
  logic [15:0] rsp_rdata;
  logic [7:0] ch_fault_pin_shutdown;
  logic [3:0] pin_in, pin_oe_n, peer_oe_n;
  logic [5:0] drv_out;
  int bad_count = 0;
  int total_checks = 0;
  // Wired-AND with pull-up
  assign pin_in = pin_oe_n & peer_oe_n;
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  fault_zone_peer peer_u (.ref_clk(ref_clk), .hold_low(hold_low), .pull_oe_n(peer_oe_n));
  fault_zone_powergood #(.BASE_TIMEOUT_CYCLES(BASE)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .bus_busy(bus_busy), .bus_activity(bus_activity), .pec_required(pec_required),
    .bus_timeout(bus_timeout), .vin_en_forced_off(vin_en_forced_off),
    .vin_en_pullup_on(vin_en_pullup_on), .vin_en_out(drv_out[4]), .vin_en_oe_n(vin_en_oe_n),
    .ch_faulted_off(ch_faulted_off), .ch_power_good(ch_power_good), .ch_high_res(ch_high_res),
    .wdog_not_expired(wdog_not_expired), .ch_fault_pin_shutdown(ch_fault_pin_shutdown),
    .power_good(power_good), .zone0_fault_pin_a_in(pin_in[0]),
    .zone0_fault_pin_a_out(drv_out[0]), .zone0_fault_pin_a_oe_n(pin_oe_n[0]),
    .zone0_fault_pin_b_in(pin_in[1]), .zone0_fault_pin_b_out(drv_out[1]),
    .zone0_fault_pin_b_oe_n(pin_oe_n[1]), .zone1_fault_pin_a_in(pin_in[2]),
    .zone1_fault_pin_a_out(drv_out[2]), .zone1_fault_pin_a_oe_n(pin_oe_n[2]),
    .zone1_fault_pin_b_in(pin_in[3]), .zone1_fault_pin_b_out(drv_out[3]),
    .zone1_fault_pin_b_oe_n(pin_oe_n[3]), .alert_output_out(drv_out[5]),
    .alert_output_oe_n(alert_output_oe_n));
  // ==========================================================
  // Tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One command, answer checked the cycle after it is taken
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [2:0] page,
                     input logic [15:0] data, input logic [15:0] exp);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_page = page;
    cmd_wdata = data;
    idle(1);
    chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
    chk("rsp_rdata", exp, rsp_rdata);
    er = rsp_error;
    cmd_valid = 1'b0;
  endtask
  task automatic pg(input logic [15:0] en, input logic [7:0] good, input logic [7:0] hr,
                    input logic wd, input logic exp);
    cmd(1'b1, fault_zone_pkg::CMD_PWRGD_EN, 3'h0, en, 16'h0);
    ch_power_good = good;
    ch_high_res = hr;
    wdog_not_expired = wd;
    idle(2);
    chk("power_good", {15'h0, exp}, {15'h0, power_good});
  endtask
  task automatic time_out(input int lo, input int hi);
    int n;
    n = 0;
    @(negedge ref_clk);
    bus_busy = 1'b1;
    bus_activity = 1'b1;
    idle(1);
    bus_activity = 1'b0;
    while (bus_timeout !== 1'b1 && n < 400) begin
      idle(1);
      n++;
    end
    if (n == 400) begin
      bad_count++;
      complete_run();
    end
    chk("timeout_in_range", 16'h0001, {15'h0, n >= lo && n <= hi});
    bus_busy = 1'b0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    idle(20);
    rst = 1'b0;
    for (int c = fault_zone_pkg::CMD_CONFIG_ALL; c <= fault_zone_pkg::CMD_PIN_STATUS; c++) begin
      cmd(1'b0, 8'(c), 3'h0, 16'h0, 16'h0);
    end
    cmd(1'b1, fault_zone_pkg::CMD_CONFIG_ALL, 3'h0, 16'hffff, 16'h0);
    cmd(1'b0, fault_zone_pkg::CMD_CONFIG_ALL, 3'h0, 16'h0, fault_zone_pkg::CFG_WRITE_MASK);
    chk("pec_required", 16'h0001, {15'h0, pec_required});
    chk("pullup", 16'h0000, {15'h0, vin_en_pullup_on});
    chk("vin_en_oe_n", 16'h0001, {15'h0, vin_en_oe_n});
    time_out(8 * BASE - 3, 8 * BASE + 3);
    cmd(1'b1, fault_zone_pkg::CMD_CONFIG_ALL, 3'h0, 16'h0000, 16'h0);
    idle(1);
    chk("pec_required", 16'h0000, {15'h0, pec_required});
    chk("pullup", 16'h0001, {15'h0, vin_en_pullup_on});
    time_out(BASE - 3, BASE + 3);
    vin_en_forced_off = 1'b1;
    idle(2);
    chk("pullup", 16'h0000, {15'h0, vin_en_pullup_on});
    chk("vin_en_oe_n", 16'h0000, {15'h0, vin_en_oe_n});
    vin_en_forced_off = 1'b0;
    cmd(1'b1, 8'h00, 3'h0, 16'hffff, 16'h0);
    chk("rsp_error", 16'h0001, {15'h0, er});
    cmd(1'b0, fault_zone_pkg::CMD_CONFIG_ALL, 3'h0, 16'h0, 16'h0);
    // Odd channels on the first pin, even on the second
    for (int k = 0; k < 8; k++) begin
      cmd(1'b1, fault_zone_pkg::CMD_PROPAGATE_A, 3'(k), 16'hfffe | 16'(k[0]), 16'h0);
      cmd(1'b0, fault_zone_pkg::CMD_PROPAGATE_A, 3'(k), 16'h0, 16'(k[0]));
      cmd(1'b1, fault_zone_pkg::CMD_PROPAGATE_B, 3'(k), 16'hfffe | 16'(!k[0]), 16'h0);
      ch_faulted_off = 8'h01 << k;
      idle(2);
      chk("pin_oe_n", {12'h0, ~(4'h1 << (k / 4 * 2 + !k[0]))}, {12'h0, pin_oe_n});
      ch_faulted_off = 8'h00;
      idle(2);
      chk("pin_oe_n", 16'h000f, {12'h0, pin_oe_n});
    end
    pg(16'h000f, 8'h0f, 8'h00, 1'b1, 1'b1);
    pg(16'h000f, 8'h07, 8'h00, 1'b1, 1'b0);
    pg(16'h0002, 8'h00, 8'h02, 1'b1, 1'b1);
    pg(16'h0001, 8'h00, 8'h01, 1'b1, 1'b0);
    pg(16'h01ff, 8'hff, 8'h00, 1'b0, 1'b0);
    pg(16'h00ff, 8'hff, 8'h00, 1'b0, 1'b1);
    pg(16'h0000, 8'h00, 8'h00, 1'b0, 1'b1);
    pg(16'h01ff, 8'h55, 8'haa, 1'b1, 1'b1);
    cmd(1'b1, fault_zone_pkg::CMD_PWRGD_EN, 3'h0, 16'hffff, 16'h0);
    cmd(1'b0, fault_zone_pkg::CMD_PWRGD_EN, 3'h0, 16'h0, fault_zone_pkg::PG_WRITE_MASK);
    cmd(1'b1, fault_zone_pkg::CMD_RESPONSE_Z0A, 3'h0, 16'h0005, 16'h0);
    cmd(1'b1, fault_zone_pkg::CMD_RESPONSE_Z1B, 3'h0, 16'h0008, 16'h0);
    cmd(1'b1, fault_zone_pkg::CMD_RESPONSE_Z0B, 3'h0, 16'hfff2, 16'h0);
    cmd(1'b0, fault_zone_pkg::CMD_RESPONSE_Z0B, 3'h0, 16'h0, 16'h0002);
    cmd(1'b1, fault_zone_pkg::CMD_RESPONSE_Z1A, 3'h0, 16'hfff4, 16'h0);
    cmd(1'b0, fault_zone_pkg::CMD_RESPONSE_Z1A, 3'h0, 16'h0, 16'h0004);
    // A short pull must be filtered out
    hold_low = 4'b1001;
    idle(100);
    hold_low = 4'b0000;
    idle(4);
    chk("shutdown", 16'h0000, {8'h0, ch_fault_pin_shutdown});
    hold_low = 4'b1001;
    idle(int'(fault_zone_pkg::FILTER_LIMIT) - 10);
    chk("shutdown", 16'h0000, {8'h0, ch_fault_pin_shutdown});
    idle(20);
    chk("shutdown", 16'h0085, {8'h0, ch_fault_pin_shutdown});
    chk("alert_oe_n", 16'h0000, {15'h0, alert_output_oe_n});
    chk("drive_level", 16'h0000, {10'h0, drv_out});
    cmd(1'b0, fault_zone_pkg::CMD_PIN_STATUS, 3'h0, 16'h0, 16'h0085);
    hold_low = 4'b0000;
    idle(4);
    chk("shutdown", 16'h0000, {8'h0, ch_fault_pin_shutdown});
    cmd(1'b1, fault_zone_pkg::CMD_PIN_STATUS, 3'h0, 16'h00ff, 16'h0);
    chk("alert_oe_n", 16'h0001, {15'h0, alert_output_oe_n});
    complete_run();
  end
endmodule // fault_zone_powergood_tb
`default_nettype wire
